//--- logic/probe_pkg.sv
// cache probe register pair: shared constants, field positions and carrier types
// assumes a core-side coprocessor move port and a cache-array index port
package probe_pkg;
	localparam logic [4:0] REG_PROBE_LOW  = 5'h1c;
	localparam logic [4:0] REG_PROBE_HIGH = 5'h1d;
	localparam logic [4:0] REG_ECC        = 5'h1a;
	localparam logic [31:0] PROBE_RESET   = 32'h0000_0000;
	localparam logic [9:0]  ECC_RESET     = 10'h000;

	// primary tag layout (low word)
	localparam int P_ADDR_LO_MSB = 31;
	localparam int P_ADDR_LO_LSB = 8;
	localparam int P_STATE_MSB   = 7;
	localparam int P_STATE_LSB   = 6;
	localparam int P_LRU_BIT     = 5;
	localparam int P_STPAR_BIT   = 4;
	localparam int P_WAY_BIT     = 3;
	localparam int P_ADPAR_BIT   = 0;
	// primary tag layout (high word)
	localparam int P_MOD_MSB     = 31;
	localparam int P_MOD_LSB     = 29;
	localparam int P_ADDR_HI_MSB = 3;
	localparam int P_ADDR_HI_LSB = 0;
	// secondary tag layout (low word)
	localparam int S_ADDR_LO_MSB = 31;
	localparam int S_ADDR_LO_LSB = 14;
	localparam int S_STATE_MSB   = 11;
	localparam int S_STATE_LSB   = 10;
	localparam int S_VSET_MSB    = 8;
	localparam int S_VSET_LSB    = 7;
	localparam int S_ECC_MSB     = 6;
	localparam int S_ECC_LSB     = 0;
	// secondary tag layout (high word)
	localparam int S_MRU_BIT     = 31;
	localparam int S_ADDR_HI_MSB = 3;
	localparam int S_ADDR_HI_LSB = 0;
	// ecc register for secondary data
	localparam int E_PAR_BIT     = 9;
	localparam int E_ECC_MSB     = 8;

	localparam logic [2:0] MOD_PLAIN   = 3'b001;
	localparam logic [2:0] MOD_WRITTEN = 3'b010;
	localparam logic [2:0] MOD_REFILL  = 3'b100;

	// line states, refill clear / refill set
	localparam logic [1:0] LS_INVALID   = 2'b00;
	localparam logic [1:0] LS_SHARED    = 2'b01;
	localparam logic [1:0] LS_CLEAN_EX  = 2'b10;
	localparam logic [1:0] LS_DIRTY_EX  = 2'b11;
	localparam logic [1:0] LS_REF_CLEAN = 2'b00;
	localparam logic [1:0] LS_UPG_SHARE = 2'b01;
	localparam logic [1:0] LS_UPG_CLEAN = 2'b10;
	localparam logic [1:0] LS_REF_STORE = 2'b11;

	typedef enum logic [1:0] {TGT_ICACHE, TGT_DCACHE, TGT_SCACHE} target_t;

	// flat image of one cache entry as seen by the arrays
	typedef struct packed {
		logic [27:0] paddr;    // physical address bits 39:12
		logic [1:0]  state;
		logic [2:0]  modifier;
		logic        usage;    // lru for primary, mru for secondary
		logic        way;
		logic        st_par;
		logic        tag_par;
		logic [1:0]  vset;
		logic [6:0]  tag_ecc;
		logic [63:0] data;
		logic [9:0]  data_chk;
	} entry_t;

	typedef struct packed {
		logic       valid;
		logic       store;    // 1 = index store, 0 = index load
		logic       is_data;  // 1 = data op, 0 = tag op
		target_t    target;
	} cacheop_t;

	typedef struct packed {
		logic [31:0] low;
		logic [31:0] high;
		logic [9:0]  ecc;
	} probe_regs_t;

	function automatic logic even_par(input logic [31:0] v);
		return ^v;
	endfunction : even_par
endpackage : probe_pkg

//--- logic/probe_pack.sv
// probe_pack: builds the probe register images from a cache entry (index load)
// assumes entry fields are already valid for the selected target
`timescale 1ns/1ps
module probe_pack (
	input  wire probe_pkg::entry_t   entry,  // entry read from the array
	input  wire probe_pkg::cacheop_t op,     // operation kind and target
	output probe_pkg::probe_regs_t   image   // packed register images
);
	import probe_pkg::*;

	always_comb begin
		image = '0;
		if (!op.is_data) begin
			case (op.target)
				TGT_ICACHE, TGT_DCACHE: begin
					image.low[P_ADDR_LO_MSB:P_ADDR_LO_LSB] = entry.paddr[23:0];
					image.high[P_ADDR_HI_MSB:P_ADDR_HI_LSB] = entry.paddr[27:24];
					image.low[P_LRU_BIT] = entry.usage;
					image.low[P_ADPAR_BIT] = even_par({4'h0, entry.paddr});
					if (op.target == TGT_ICACHE) begin
						image.low[P_STATE_LSB] = entry.state[0];
						image.low[P_STPAR_BIT] = entry.state[0];
					end else begin
						image.low[P_STATE_MSB:P_STATE_LSB] = entry.state;
						image.low[P_WAY_BIT] = entry.way;
						image.low[P_STPAR_BIT] = even_par({29'h0, entry.state, entry.way});
						image.high[P_MOD_MSB:P_MOD_LSB] = entry.modifier;
					end
				end
				TGT_SCACHE: begin
					image.low[S_ADDR_LO_MSB:S_ADDR_LO_LSB] = entry.paddr[23:6];
					image.high[S_ADDR_HI_MSB:S_ADDR_HI_LSB] = entry.paddr[27:24];
					image.low[S_STATE_MSB:S_STATE_LSB] = entry.state;
					image.low[S_VSET_MSB:S_VSET_LSB] = entry.vset;
					image.low[S_ECC_MSB:S_ECC_LSB] = entry.tag_ecc;
					image.high[S_MRU_BIT] = entry.usage;
				end
				default: image = '0;
			endcase
		end else begin
			case (op.target)
				TGT_ICACHE: begin
					image.low = entry.data[31:0];
					image.high[3:0] = entry.data[35:32];
					image.ecc[0] = entry.data_chk[0];
				end
				TGT_DCACHE: begin
					image.low = entry.data[31:0];
					image.ecc[3:0] = entry.data_chk[3:0];
				end
				TGT_SCACHE: begin
					image.low = entry.data[31:0];
					image.high = entry.data[63:32];
					image.ecc = entry.data_chk;
				end
				default: image = '0;
			endcase
		end
	end
endmodule : probe_pack

//--- logic/probe_unpack.sv
// probe_unpack: turns probe register contents into a cache entry (index store)
// assumes the array writes only the fields that belong to the target
`timescale 1ns/1ps
module probe_unpack (
	input  wire probe_pkg::probe_regs_t regs,   // current register contents
	input  wire probe_pkg::cacheop_t    op,     // operation kind and target
	output probe_pkg::entry_t           entry   // entry to write
);
	import probe_pkg::*;

	always_comb begin
		entry = '0;
		if (!op.is_data) begin
			if (op.target == TGT_SCACHE) begin
				entry.paddr = {regs.high[S_ADDR_HI_MSB:S_ADDR_HI_LSB],
					regs.low[S_ADDR_LO_MSB:S_ADDR_LO_LSB], 6'h00};
				entry.state = regs.low[S_STATE_MSB:S_STATE_LSB];
				entry.vset = regs.low[S_VSET_MSB:S_VSET_LSB];
				entry.tag_ecc = regs.low[S_ECC_MSB:S_ECC_LSB];
				entry.usage = regs.high[S_MRU_BIT];
			end else begin
				entry.paddr = {regs.high[P_ADDR_HI_MSB:P_ADDR_HI_LSB],
					regs.low[P_ADDR_LO_MSB:P_ADDR_LO_LSB]};
				entry.usage = regs.low[P_LRU_BIT];
				entry.st_par = regs.low[P_STPAR_BIT];
				entry.tag_par = regs.low[P_ADPAR_BIT];
				if (op.target == TGT_ICACHE) begin
					entry.state = {1'b0, regs.low[P_STATE_LSB]};
				end else begin
					entry.state = regs.low[P_STATE_MSB:P_STATE_LSB];
					entry.way = regs.low[P_WAY_BIT];
					entry.modifier = regs.high[P_MOD_MSB:P_MOD_LSB];
				end
			end
		end else begin
			case (op.target)
				TGT_ICACHE: begin
					entry.data = {28'h0, regs.high[3:0], regs.low};
					entry.data_chk = {9'h0, regs.ecc[0]};
				end
				TGT_DCACHE: begin
					entry.data = {32'h0, regs.low};
					entry.data_chk = {6'h0, regs.ecc[3:0]};
				end
				TGT_SCACHE: begin
					entry.data = {regs.high, regs.low};
					entry.data_chk = regs.ecc;
				end
				default: entry.data = '0;
			endcase
		end
	end
endmodule : probe_unpack

//--- logic/cache_probe_register_pair.sv
// cache_probe_register_pair: low/high probe words plus check-bit register
// assumes core moves and cache ops never arrive in the same cycle; an index load
// takes priority over a move-to if they do. entry read data is valid in the cycle of the op.
`timescale 1ns/1ps
// Notes on behaviour
// - two 32-bit read/write probe registers
// - layout chosen by op kind and cache
// - reserved bits load zero, ignored on store
// - moved-in low word reads back unchanged
// - primary tag holds address 35:12, 39:36
// - instruction line state: 1 valid
// - replacement bit marks least recently used way
// - instruction state and tag even parity
// - data state parity covers state and way
// - modifier encodes 001, 010, 100
// - refill clear: invalid, shared, clean, dirty
// - refill set: refill, upgrades, store refill
// - way bit names secondary set
// - secondary tag holds address 35:18, 39:36
// - secondary state: invalid, shared, clean, dirty
// - virtual set bits are address 13:12
// - ecc covers secondary tag fields
// - usage bit marks most recent way
// - instruction data: high four bits, low rest
// - data word in low, high unused
// - doubleword split high and low
// - ecc register parity bit 9, ecc 8:0
module cache_probe_register_pair (
	input  wire logic              clk,          // core clock
	input  wire logic              rst_n,        // async reset, active low
	input  wire logic              mt_valid,     // move_to_coprocessor strobe
	input  wire logic [4:0]        mt_reg,       // destination register number
	input  wire logic [31:0]       mt_data,      // move-to data
	input  wire logic              mf_valid,     // move_from_coprocessor strobe
	input  wire logic [4:0]        mf_reg,       // source register number
	input  wire probe_pkg::cacheop_t op,         // index load/store request
	input  wire probe_pkg::entry_t rd_entry,     // entry read from the array
	output logic                   mf_ack,       // read data valid pulse
	output logic [31:0]            mf_data,      // read data
	output logic                   wr_en,        // array write pulse
	output probe_pkg::target_t     wr_target,    // array being written
	output logic                   wr_is_data,   // data rather than tag write
	output probe_pkg::entry_t      wr_entry      // entry to write
);
	import probe_pkg::*;

	typedef struct packed {
		probe_regs_t regs;
		logic        ack;
		logic [31:0] rdata;
		logic        wen;
		target_t     wtgt;
		logic        wdata_op;
		entry_t      went;
	} state_t;

	state_t      cur_ff;
	state_t      nxt_cur;
	probe_regs_t loaded;
	entry_t      stored;

	probe_pack u_pack (
		.entry (rd_entry),
		.op    (op),
		.image (loaded)
	);

	probe_unpack u_unpack (
		.regs  (cur_ff.regs),
		.op    (op),
		.entry (stored)
	);

	always_comb begin
		nxt_cur = cur_ff;
		nxt_cur.ack = 1'b0;
		nxt_cur.wen = 1'b0;
		if (op.valid && !op.store) begin
			nxt_cur.regs.low = loaded.low;
			nxt_cur.regs.high = loaded.high;
			if (op.is_data) begin
				nxt_cur.regs.ecc = loaded.ecc;
			end
		end else if (mt_valid) begin
			case (mt_reg)
				REG_PROBE_LOW: nxt_cur.regs.low = mt_data;
				REG_PROBE_HIGH: nxt_cur.regs.high = mt_data;
				REG_ECC: nxt_cur.regs.ecc = mt_data[E_PAR_BIT:0];
				default: nxt_cur.regs = cur_ff.regs;
			endcase
		end
		if (op.valid && op.store) begin
			nxt_cur.wen = 1'b1;
			nxt_cur.wtgt = op.target;
			nxt_cur.wdata_op = op.is_data;
			nxt_cur.went = stored;
		end
		if (mf_valid) begin
			nxt_cur.ack = 1'b1;
			case (mf_reg)
				REG_PROBE_LOW: nxt_cur.rdata = cur_ff.regs.low;
				REG_PROBE_HIGH: nxt_cur.rdata = cur_ff.regs.high;
				REG_ECC: nxt_cur.rdata = {22'h0, cur_ff.regs.ecc};
				default: nxt_cur.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cur_ff <= '0;
			cur_ff.regs.low <= PROBE_RESET;
			cur_ff.regs.high <= PROBE_RESET;
			cur_ff.regs.ecc <= ECC_RESET;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	assign mf_ack = cur_ff.ack;
	assign mf_data = cur_ff.rdata;
	assign wr_en = cur_ff.wen;
	assign wr_target = cur_ff.wtgt;
	assign wr_is_data = cur_ff.wdata_op;
	assign wr_entry = cur_ff.went;
endmodule : cache_probe_register_pair

//--- testbench/probe_chk_sva.sv
// probe pair checker: port-level timing and load layouts
// assumes moves and cache ops are kept in separate cycles by the driver
`timescale 1ns/1ps
module probe_chk
	import probe_pkg::*;
(
	input wire logic        clk,        // clock
	input wire logic        rst_n,      // reset
	input wire logic        mt_valid,   // move-to
	input wire logic [4:0]  mt_reg,     // move-to reg
	input wire logic [31:0] mt_data,    // move-to data
	input wire logic        mf_valid,   // move-from
	input wire logic [4:0]  mf_reg,     // move-from reg
	input wire cacheop_t    op,         // cache op
	input wire entry_t      rd_entry,   // array read
	input wire logic        mf_ack,     // read ack
	input wire logic [31:0] mf_data,    // read data
	input wire logic        wr_en,      // array write
	input wire target_t     wr_target,  // write target
	input wire logic        wr_is_data, // data write
	input wire entry_t      wr_entry    // write entry
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_q; !op.valid && !mt_valid; endsequence
	sequence s_ld(d, t); op.valid && !op.store && op.is_data == d && op.target == t; endsequence
	sequence s_rd(r); mf_valid && mf_reg == r && !op.valid && !mt_valid; endsequence
	AST_ACK: assert property (mf_valid |=> mf_ack)
		else $error("read not acked");
	AST_ACK_CAUSE: assert property (mf_ack |-> $past(mf_valid))
		else $error("stray ack");
	AST_WR: assert property (op.valid && op.store |=> wr_en
		&& wr_target == $past(op.target) && wr_is_data == $past(op.is_data))
		else $error("store not written");
	AST_WR_CAUSE: assert property (wr_en |-> $past(op.valid && op.store))
		else $error("stray write");
	AST_LOW: assert property (mt_valid && mt_reg == REG_PROBE_LOW && !op.valid ##1 s_q
		##1 s_rd(REG_PROBE_LOW) |=> mf_data == $past(mt_data, 3))
		else $error("low word lost");
	AST_DDATA: assert property (s_ld(1, TGT_DCACHE) ##1 s_q[*3]
		##1 s_rd(REG_PROBE_HIGH) |=> mf_data == 32'h0)
		else $error("high not zero");
	AST_SDATA: assert property (s_ld(1, TGT_SCACHE) ##1 s_q
		##1 s_rd(REG_PROBE_LOW) |=> mf_data == $past(rd_entry.data[31:0], 3))
		else $error("low data wrong");
	AST_PTAG: assert property (s_ld(0, TGT_DCACHE) ##1 s_q[*3]
		##1 s_rd(REG_PROBE_HIGH)
		|=> mf_data[3:0] == $past(rd_entry.paddr[27:24], 5) && mf_data[28:4] == 0)
		else $error("tag high wrong");
endmodule : probe_chk
bind cache_probe_register_pair probe_chk u_chk (.clk(clk), .rst_n(rst_n), .mt_valid(mt_valid),
	.mt_reg(mt_reg), .mt_data(mt_data), .mf_valid(mf_valid), .mf_reg(mf_reg), .op(op),
	.rd_entry(rd_entry), .mf_ack(mf_ack), .mf_data(mf_data), .wr_en(wr_en),
	.wr_target(wr_target), .wr_is_data(wr_is_data), .wr_entry(wr_entry));

//--- testbench/cache_probe_register_pair_bench.sv
// bench for the probe register pair: moves, index loads and stores
// assumes the hand-over timing: ack and write one cycle after the request
`timescale 1ns/1ps
module cache_probe_register_pair_bench;
	import probe_pkg::*;
	logic clk, rst_n, mt_valid, mf_valid, mf_ack, wr_en, wr_is_data;
	logic [4:0] mt_reg, mf_reg;
	logic [31:0] mt_data, mf_data, d;
	cacheop_t op;
	entry_t rd_entry, wr_entry, e;
	target_t wr_target, t;
	probe_regs_t ex;
	logic [127:0] rn;
	logic [9:0] ecc_now;
	int err_count = 0, n_checks = 0;
	integer seed = 32'h98c8;
	cache_probe_register_pair dut (.clk(clk), .rst_n(rst_n), .mt_valid(mt_valid),
		.mt_reg(mt_reg), .mt_data(mt_data), .mf_valid(mf_valid), .mf_reg(mf_reg), .op(op),
		.rd_entry(rd_entry), .mf_ack(mf_ack), .mf_data(mf_data), .wr_en(wr_en),
		.wr_target(wr_target), .wr_is_data(wr_is_data), .wr_entry(wr_entry));
	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : summarize
	task automatic mt(logic [4:0] r, logic [31:0] v);
		mt_valid = 1;
		mt_reg = r;
		mt_data = v;
		@(posedge clk);
		#5 mt_valid = 0;
		@(posedge clk);
		#5;
	endtask : mt
	task automatic rd(logic [4:0] r, logic [31:0] exp);
		mf_valid = 1;
		mf_reg = r;
		@(posedge clk);
		#5 mf_valid = 0;
		chk("ack", mf_ack, 1);
		chk("rdata", mf_data, exp);
		@(posedge clk);
		#5 chk("ack pulse", mf_ack, 0);
	endtask : rd
	task automatic cop(logic st, logic dt, target_t tg, entry_t en);
		op = '{1'b1, st, dt, tg};
		rd_entry = en;
		@(posedge clk);
		#5 op.valid = 0;
		if (st) begin
			chk("wr_en", wr_en, 1);
			chk("wr_tgt", wr_target, tg);
			chk("wr_data", wr_is_data, dt);
		end
		@(posedge clk); #5;
	endtask : cop
	function automatic probe_regs_t expect_regs(entry_t x, logic dt, target_t tg);
		probe_regs_t r;
		r = '0;
		r.ecc = ecc_now;
		if (!dt && tg != TGT_SCACHE) begin
			r.low[31:8] = x.paddr[23:0];
			r.high[3:0] = x.paddr[27:24];
			r.low[5] = x.usage;
			r.low[0] = ^x.paddr;
			if (tg == TGT_ICACHE) {r.low[6], r.low[4]} = {2{x.state[0]}};
			else begin
				{r.low[7:6], r.low[4], r.low[3]} = {x.state, ^{x.state, x.way}, x.way};
				r.high[31:29] = x.modifier;
			end
		end else if (!dt) begin
			{r.low[31:14], r.low[11:10]} = {x.paddr[23:6], x.state};
			{r.low[8:7], r.low[6:0]} = {x.vset, x.tag_ecc};
			{r.high[31], r.high[3:0]} = {x.usage, x.paddr[27:24]};
		end else begin
			r.low = x.data[31:0];
			r.ecc = '0;
			if (tg == TGT_ICACHE) {r.high[3:0], r.ecc[0]} = {x.data[35:32], x.data_chk[0]};
			else if (tg == TGT_DCACHE) r.ecc[3:0] = x.data_chk[3:0];
			else {r.high, r.ecc} = {x.data[63:32], x.data_chk};
		end
		return r;
	endfunction : expect_regs
	initial begin
		#2000000 err_count++;
		summarize();
	end
	initial begin
		{rst_n, mt_valid, mf_valid, mt_reg, mf_reg, mt_data} = '0;
		op = '0; rd_entry = '0; ecc_now = '0;
		repeat (16) @(posedge clk);
		#5 rst_n = 1;
		rd(REG_PROBE_LOW, 0);
		rd(REG_PROBE_HIGH, 0);
		rd(REG_ECC, 0);
		$display("test reset values done");
		for (int i = 0; i < 6; i++) begin
			d = (i == 0) ? 32'hffff_ffff : $random(seed);
			mt(REG_PROBE_LOW, d);
			rd(REG_PROBE_LOW, d);
			mt(REG_PROBE_HIGH, ~d);
			rd(REG_PROBE_HIGH, ~d);
			mt(REG_ECC, d);
			ecc_now = d[9:0];
			rd(REG_ECC, {22'h0, ecc_now});
		end
		mt(5'h1b, 32'hffff_ffff);
		rd(5'h1b, 0);
		rd(REG_PROBE_LOW, d);
		$display("test moves done");
		for (int k = 0; k < 12; k++) begin
			rn = {$random(seed), $random(seed), $random(seed), $random(seed)};
			e = (k < 6) ? rn[119:0] : '1;
			t = target_t'(k % 3);
			cop(0, k % 6 > 2, t, e);
			ex = expect_regs(e, k % 6 > 2, t);
			ecc_now = ex.ecc;
			rd(REG_PROBE_LOW, ex.low);
			rd(REG_PROBE_HIGH, ex.high);
			rd(REG_ECC, {22'h0, ex.ecc});
			cop(1, k % 6 > 2, t, '0);
			if (k % 6 > 2) chk("st_data", wr_entry.data[31:0], e.data[31:0]);
			else chk("st_tag", wr_entry.paddr[27:24], e.paddr[27:24]);
		end
		$display("test loads and stores done");
		mt(REG_PROBE_LOW, 32'hffff_ffff);
		mt(REG_PROBE_HIGH, 32'hffff_ffff);
		cop(1, 0, TGT_DCACHE, '0);
		chk("st_vset", wr_entry.vset, 0);
		chk("st_mod", wr_entry.modifier, 3'h7);
		$display("test reserved store done");
		summarize();
	end
endmodule : cache_probe_register_pair_bench
